// ==== rtl/gpr_pkg.sv ====
// Purpose: Shared constants and types for the GPIO port block with routing matrix
// Assumes: APB slave with 32-bit data, one word per register
// Notes: Five ports; the last one is half populated
package gpr_pkg;
    localparam int NPORT = 5;
    localparam int NPIN = 8;
    localparam int SEL_W = 4;
    localparam int DM_W = 3;
    localparam logic [7:0] LAST_PORT_MASK = 8'h0F;
    // Per-port register block: 0x40 bytes per port
    localparam logic [11:0] PORT_STRIDE = 12'h040;
    localparam logic [5:0] OFF_OUT = 6'h00;
    localparam logic [5:0] OFF_PIN = 6'h04;
    localparam logic [5:0] OFF_DM = 6'h08;
    localparam logic [5:0] OFF_CFG = 6'h0C;
    localparam logic [5:0] OFF_ROUTE = 6'h10;
    localparam logic [5:0] OFF_INTST = 6'h14;
    localparam logic [5:0] OFF_INTMSK = 6'h18;
    localparam logic [5:0] OFF_HOLD = 6'h1C;
    // Config word bit positions
    localparam int CFG_INEN = 0;
    localparam int CFG_OUTEN = 8;
    localparam int CFG_VTRIP = 16;
    localparam int CFG_SLEW = 24;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    // Drive modes
    typedef enum logic [2:0] {
        DM_ANALOG = 3'h0,
        DM_INPUT = 3'h1,
        DM_WUP_SDN = 3'h2,
        DM_SUP_WDN = 3'h3,
        DM_OD_LOW = 3'h4,
        DM_OD_HIGH = 3'h5,
        DM_STRONG = 3'h6,
        DM_WEAK = 3'h7
    } gpr_dmode_t;
    // Route select codes
    localparam logic [3:0] SEL_FW = 4'h0;
    localparam logic [3:0] SEL_FW_OUT_IC_OE = 4'h1;
    localparam logic [3:0] SEL_IC = 4'h2;
    localparam logic [3:0] SEL_IC_OUT_FW_OE = 4'h3;
    localparam logic [3:0] SEL_ACT0 = 4'h8;
    localparam logic [3:0] SEL_RSVD = 4'hB;
    localparam logic [3:0] SEL_DS1 = 4'hF;
    // Per pin pad controls
    typedef struct packed {
        logic [NPIN-1:0] dout;
        logic [NPIN-1:0] oe_n;
        logic [NPIN-1:0] strong_up;
        logic [NPIN-1:0] strong_dn;
        logic [NPIN-1:0] weak_up;
        logic [NPIN-1:0] weak_dn;
        logic [NPIN-1:0] in_en;
        logic [NPIN-1:0] lvttl;
        logic [NPIN-1:0] slow;
    } gpr_pad_t;
    typedef struct packed {
        logic [NPIN-1:0] dout;
        logic [NPIN-1:0] oe;
    } gpr_sig_t;
endpackage : gpr_pkg

// ==== rtl/gpr_port.sv ====
// Purpose: GPIO ports with drive modes, hold, per-pin interrupts and routing matrix
// Assumes: APB slave, pins synchronous to clk, pad cell resolves weak/strong drive
// Notes: Each port: out, pin state, drive mode, config, route, int status, int mask, hold
// Operation
// - Eight drive modes per pin, from analog off to weak both ways.
// - Input threshold selectable per pin, CMOS or LVTTL.
// - Separate input and output buffer enables, acting on top of drive mode.
// - Hold latches the last driven pad state through low-power modes.
// - Per pin slew-rate select limits edge rate.
// - Ports of eight pins, per-port registers hold a bit or field per pin.
// - Reset forces all pin buffers disabled.
// - Output-data register drives pins; pin-state register reads actual levels.
// - A pin raises an interrupt only when enabled.
// - One interrupt line per port, five in total, last port half populated.
// - Fixed peripherals use fixed pins; interconnect signals reach any pin.
// - One 32-bit route register per port, four bits per pin, sixteen options.
// - Codes 0-3 pick firmware or interconnect for output and enable.
// - Codes 4-15 select sensing, analog buses, peripheral and sleep functions.
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module gpr_port
    import gpr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins
    input wire logic [gpr_pkg::NPORT*gpr_pkg::NPIN-1:0] pin_in,
    output gpr_pkg::gpr_pad_t [gpr_pkg::NPORT-1:0] pad,
    // Interconnect, fixed peripherals (indexed by route code 8..15)
    input wire gpr_pkg::gpr_sig_t [gpr_pkg::NPORT-1:0] ic_sig,
    input wire gpr_pkg::gpr_sig_t [gpr_pkg::NPORT-1:0][7:0] periph_sig,
    output logic [gpr_pkg::NPORT*gpr_pkg::NPIN-1:0] ic_in,
    // Analog connections
    output logic [gpr_pkg::NPORT*gpr_pkg::NPIN-1:0] sense_en,
    output logic [gpr_pkg::NPORT*gpr_pkg::NPIN-1:0] shield_en,
    output logic [gpr_pkg::NPORT*gpr_pkg::NPIN-1:0] bus_a_en,
    output logic [gpr_pkg::NPORT*gpr_pkg::NPIN-1:0] bus_b_en,
    // Interrupts
    output logic [gpr_pkg::NPORT-1:0] port_irq
);
    import gpr_pkg::*;

    // Route codes for the analog and display uses of a pin
    localparam logic [3:0] SEL_SENSE = 4'h4;
    localparam logic [3:0] SEL_SHIELD = 4'h5;
    localparam logic [3:0] SEL_BUS_A = 4'h6;
    localparam logic [3:0] SEL_BUS_B = 4'h7;
    localparam logic [3:0] SEL_DISP_COM = 4'hC;
    localparam logic [3:0] SEL_DISP_SEG = 4'hD;

    logic [NPORT-1:0][7:0] out_q, msk_q, st_q, hold_q, pin_q, pin_prev_q;
    logic [NPORT-1:0][23:0] dm_q;
    logic [NPORT-1:0][31:0] cfg_q, route_q;
    gpr_pad_t [NPORT-1:0] pad_live, pad_q;

    function automatic logic [7:0] pmask(input int p);
        pmask = (p == NPORT - 1) ? LAST_PORT_MASK : 8'hFF;
    endfunction : pmask

    // Address decode
    wire [2:0] a_port = 3'(paddr[11:6]);
    wire [5:0] a_off = paddr[5:0];
    wire a_port_ok = (paddr[11:6] < 6'(NPORT));
    wire a_off_ok = (a_off <= OFF_HOLD) && (a_off[1:0] == 2'b00);
    wire a_ok = a_port_ok && a_off_ok;
    wire acc = psel && penable;
    wire wr_en = acc && pwrite && a_ok;
    wire rd_en = acc && !pwrite && a_ok;
    assign pready = 1'b1;
    assign pslverr = acc && !a_ok;

    // Pin-state sampling and edge detection
    wire [NPORT-1:0][7:0] pin_edge;
    genvar gp, gb;
    generate
        for (gp = 0; gp < NPORT; gp++)
        begin : g_port
            wire [7:0] pm = pmask(gp);
            assign pin_edge[gp] = (pin_q[gp] ^ pin_prev_q[gp]) & pm;
            for (gb = 0; gb < NPIN; gb++)
            begin : g_pin
                wire [3:0] sel = route_q[gp][gb*SEL_W +: SEL_W];
                wire [2:0] dm = dm_q[gp][gb*DM_W +: DM_W];
                wire dm_ob = (dm != 3'(DM_ANALOG)) && (dm != 3'(DM_INPUT));
                wire dsel = sel[3] && (sel != SEL_RSVD) && (sel < SEL_DISP_COM || sel > SEL_DISP_SEG);
                wire pf_out = periph_sig[gp][3'(sel - SEL_ACT0)].dout[gb];
                wire pf_oe = periph_sig[gp][3'(sel - SEL_ACT0)].oe[gb];
                wire d_fw = (sel == SEL_FW) || (sel == SEL_FW_OUT_IC_OE);
                wire e_fw = (sel == SEL_FW) || (sel == SEL_IC_OUT_FW_OE);
                wire dat = dsel ? pf_out : (d_fw ? out_q[gp][gb] : ic_sig[gp].dout[gb]);
                wire oe_raw = dsel ? pf_oe : (sel < SEL_SENSE) && (e_fw ? 1'b1 : ic_sig[gp].oe[gb]);
                wire obuf = oe_raw && dm_ob && cfg_q[gp][CFG_OUTEN + gb] && pm[gb];
                wire su = obuf && dat && (dm == 3'(DM_SUP_WDN) || dm == 3'(DM_OD_HIGH) || dm == 3'(DM_STRONG));
                wire sd = obuf && !dat && (dm == 3'(DM_WUP_SDN) || dm == 3'(DM_OD_LOW) || dm == 3'(DM_STRONG));
                wire wu = obuf && dat && (dm == 3'(DM_WUP_SDN) || dm == 3'(DM_WEAK));
                wire wd = obuf && !dat && (dm == 3'(DM_SUP_WDN) || dm == 3'(DM_WEAK));
                assign pad_live[gp].dout[gb] = dat;
                assign pad_live[gp].oe_n[gb] = !(su || sd);
                assign pad_live[gp].strong_up[gb] = su;
                assign pad_live[gp].strong_dn[gb] = sd;
                assign pad_live[gp].weak_up[gb] = wu;
                assign pad_live[gp].weak_dn[gb] = wd;
                assign pad_live[gp].in_en[gb] = (dm != 3'(DM_ANALOG)) && cfg_q[gp][CFG_INEN + gb]
                    && pm[gb];
                assign pad_live[gp].lvttl[gb] = cfg_q[gp][CFG_VTRIP + gb];
                assign pad_live[gp].slow[gb] = cfg_q[gp][CFG_SLEW + gb];
                assign ic_in[gp*NPIN + gb] = pin_q[gp][gb];
                assign sense_en[gp*NPIN + gb] = (sel == SEL_SENSE) && pm[gb];
                assign shield_en[gp*NPIN + gb] = (sel == SEL_SHIELD) && pm[gb];
                assign bus_a_en[gp*NPIN + gb] = (sel == SEL_BUS_A) && pm[gb];
                assign bus_b_en[gp*NPIN + gb] = (sel == SEL_BUS_B) && pm[gb];
            end
        end
    endgenerate

    // Pad outputs: hold freezes the last pad state
    always_ff @(posedge clk)
    begin
        for (int p = 0; p < NPORT; p++)
        begin
            for (int b = 0; b < NPIN; b++)
            begin
                if (sys_rst)
                begin
                    pad_q[p].dout[b] <= 1'b0;
                    pad_q[p].oe_n[b] <= 1'b1;
                    pad_q[p].strong_up[b] <= 1'b0;
                    pad_q[p].strong_dn[b] <= 1'b0;
                    pad_q[p].weak_up[b] <= 1'b0;
                    pad_q[p].weak_dn[b] <= 1'b0;
                    pad_q[p].in_en[b] <= 1'b0;
                    pad_q[p].lvttl[b] <= 1'b0;
                    pad_q[p].slow[b] <= 1'b0;
                end
                else if (!hold_q[p][b])
                begin
                    pad_q[p].dout[b] <= pad_live[p].dout[b];
                    pad_q[p].oe_n[b] <= pad_live[p].oe_n[b];
                    pad_q[p].strong_up[b] <= pad_live[p].strong_up[b];
                    pad_q[p].strong_dn[b] <= pad_live[p].strong_dn[b];
                    pad_q[p].weak_up[b] <= pad_live[p].weak_up[b];
                    pad_q[p].weak_dn[b] <= pad_live[p].weak_dn[b];
                    pad_q[p].in_en[b] <= pad_live[p].in_en[b];
                    pad_q[p].lvttl[b] <= pad_live[p].lvttl[b];
                    pad_q[p].slow[b] <= pad_live[p].slow[b];
                end
            end
        end
    end
    assign pad = pad_q;

    // Registers
    always_ff @(posedge clk)
    begin
        for (int p = 0; p < NPORT; p++)
        begin
            if (sys_rst)
            begin
                out_q[p] <= 8'h00;
                dm_q[p] <= 24'h000000;
                cfg_q[p] <= RST_ZERO;
                route_q[p] <= RST_ZERO;
                msk_q[p] <= 8'h00;
                hold_q[p] <= 8'h00;
                st_q[p] <= 8'h00;
                pin_q[p] <= 8'h00;
                pin_prev_q[p] <= 8'h00;
            end
            else
            begin
                pin_q[p] <= pin_in[p*NPIN +: NPIN] & pmask(p);
                pin_prev_q[p] <= pin_q[p];
                if (wr_en && a_port == 3'(p))
                begin
                    if (a_off == OFF_OUT) out_q[p] <= pwdata[7:0] & pmask(p);
                    if (a_off == OFF_DM) dm_q[p] <= pwdata[23:0];
                    if (a_off == OFF_CFG) cfg_q[p] <= pwdata;
                    if (a_off == OFF_ROUTE) route_q[p] <= pwdata;
                    if (a_off == OFF_INTMSK) msk_q[p] <= pwdata[7:0] & pmask(p);
                    if (a_off == OFF_HOLD) hold_q[p] <= pwdata[7:0] & pmask(p);
                end
                // Set wins over read-clear
                if (rd_en && a_port == 3'(p) && a_off == OFF_INTST)
                    st_q[p] <= pin_edge[p];
                else
                    st_q[p] <= st_q[p] | pin_edge[p];
            end
        end
    end

    always_comb
    begin
        for (int p = 0; p < NPORT; p++)
            port_irq[p] = |(st_q[p] & msk_q[p]);
    end

    // Read mux
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (a_off)
            OFF_OUT: rd_mux = {24'h000000, out_q[a_port]};
            OFF_PIN: rd_mux = {24'h000000, pin_q[a_port]};
            OFF_DM: rd_mux = {8'h00, dm_q[a_port]};
            OFF_CFG: rd_mux = cfg_q[a_port];
            OFF_ROUTE: rd_mux = route_q[a_port];
            OFF_INTST: rd_mux = {24'h000000, st_q[a_port]};
            OFF_INTMSK: rd_mux = {24'h000000, msk_q[a_port]};
            OFF_HOLD: rd_mux = {24'h000000, hold_q[a_port]};
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    assign prdata = (acc && !pwrite && a_ok) ? rd_mux : 32'h0000_0000;

    // Checks
    a_irq_masked: assert property (@(posedge clk) disable iff (sys_rst)
        (msk_q == '0) |-> (port_irq == '0)) else $error("irq without enable");
    a_irq_pending: assert property (@(posedge clk) disable iff (sys_rst)
        (|(st_q[0] & msk_q[0])) |-> port_irq[0]) else $error("irq0 missing");
    a_flag_sticky: assert property (@(posedge clk) disable iff (sys_rst)
        (st_q[0][0] && !(rd_en && a_port == 3'h0 && a_off == OFF_INTST)) |=> st_q[0][0])
        else $error("flag lost");
    a_reset_off: assert property (@(posedge clk)
        $past(sys_rst) |-> (pad[0].oe_n == 8'hFF && pad[0].in_en == 8'h00)) else $error("buffers on after reset");
    a_hold_keep: assert property (@(posedge clk) disable iff (sys_rst)
        (hold_q[1][0] && $past(hold_q[1][0])) |-> $stable(pad[1].oe_n[0])) else $error("hold moved pad");
    a_pin_state: assert property (@(posedge clk) disable iff (sys_rst)
        rd_en && a_off == OFF_PIN |-> prdata[7:0] == pin_q[a_port]) else $error("pin state read wrong");
    a_analog_off: assert property (@(posedge clk) disable iff (sys_rst)
        (dm_q[0][2:0] == 3'(DM_ANALOG) && !hold_q[0][0]) |=> (pad[0].oe_n[0] && !pad[0].in_en[0]))
        else $error("analog mode buffer on");
    a_last_half: assert property (@(posedge clk) disable iff (sys_rst)
        (st_q[NPORT-1][7:4] == 4'h0)) else $error("unpopulated pin flagged");

    // Steps of a status read, of an output write and of a pin held for two cycles
    sequence s_stat_read2;
        rd_en && a_port == 3'h2 && a_off == OFF_INTST;
    endsequence
    sequence s_quiet_pins2;
        pin_edge[2] == 8'h00;
    endsequence
    sequence s_out_write1;
        wr_en && a_port == 3'h1 && a_off == OFF_OUT;
    endsequence
    sequence s_held_twice;
        hold_q[1][6] ##1 hold_q[1][6];
    endsequence

    property p_read_clears;
        @(posedge clk) disable iff (sys_rst)
        (s_stat_read2 ##0 s_quiet_pins2) |=> (st_q[2] == 8'h00);
    endproperty
    property p_write_lands;
        @(posedge clk) disable iff (sys_rst)
        s_out_write1 |=> (out_q[1] == $past(pwdata[7:0]));
    endproperty
    property p_hold_dout;
        @(posedge clk) disable iff (sys_rst)
        s_held_twice |-> $stable(pad[1].dout[6]);
    endproperty

    a_read_clear: assert property (p_read_clears) else $error("status not cleared by read");
    a_write_lands: assert property (p_write_lands) else $error("output data write lost");
    a_hold_dout: assert property (p_hold_dout) else $error("hold let output data move");
    a_edge_sets: assert property (@(posedge clk) disable iff (sys_rst)
        pin_edge[2][0] |=> st_q[2][0]) else $error("pin edge not flagged");
    a_bad_access: assert property (@(posedge clk) disable iff (sys_rst)
        (acc && !a_ok) |-> (pslverr && prdata == 32'h0000_0000)) else $error("bad access answered");
    a_strong_on: assert property (@(posedge clk) disable iff (sys_rst)
        (dm_q[1][20:18] == 3'(DM_STRONG) && route_q[1][27:24] == SEL_FW && cfg_q[1][CFG_OUTEN + 6]
        && !hold_q[1][6]) |=> !pad[1].oe_n[6]) else $error("strong mode not driving");
    a_input_only: assert property (@(posedge clk) disable iff (sys_rst)
        (dm_q[1][5:3] == 3'(DM_INPUT) && !hold_q[1][1]) |=> pad[1].oe_n[1]) else $error("input mode driving");
    a_outen_gate: assert property (@(posedge clk) disable iff (sys_rst)
        (!cfg_q[0][CFG_OUTEN] && !hold_q[0][0]) |=> pad[0].oe_n[0]) else $error("output buffer not gated");
    a_inen_gate: assert property (@(posedge clk) disable iff (sys_rst)
        (!cfg_q[1][CFG_INEN] && !hold_q[1][0]) |=> !pad[1].in_en[0]) else $error("input buffer not gated");
    a_slew_follow: assert property (@(posedge clk) disable iff (sys_rst)
        !hold_q[1][0] |=> (pad[1].slow[0] == $past(cfg_q[1][CFG_SLEW]))) else $error("slew not applied");
    a_vtrip_follow: assert property (@(posedge clk) disable iff (sys_rst)
        !hold_q[1][1] |=> (pad[1].lvttl[1] == $past(cfg_q[1][CFG_VTRIP + 1]))) else $error("threshold not applied");
    a_sense_route: assert property (@(posedge clk) disable iff (sys_rst)
        (route_q[3][19:16] == SEL_SENSE) |-> sense_en[3*NPIN + 4]) else $error("sense route missing");
    a_bus_b_route: assert property (@(posedge clk) disable iff (sys_rst)
        (route_q[3][31:28] == SEL_BUS_B) |-> bus_b_en[3*NPIN + 7]) else $error("bus b route missing");
endmodule : gpr_port

// ==== sim/gpr_board.sv ====
// Purpose: Board model that resolves each pin level from the pad controls
// Assumes: The bench may drive a pin externally where the pad does not drive it
// Notes: A floating pin toggles so that a stale level is never mistaken for a driven one
`timescale 1ns/1ps
module gpr_board
    import gpr_pkg::*;
(
    // Clock
    input wire logic clk,
    // Pad side
    input wire gpr_pkg::gpr_pad_t [gpr_pkg::NPORT-1:0] pad,
    input wire logic [gpr_pkg::NPORT*gpr_pkg::NPIN-1:0] ext_en,
    input wire logic [gpr_pkg::NPORT*gpr_pkg::NPIN-1:0] ext_val,
    output logic [gpr_pkg::NPORT*gpr_pkg::NPIN-1:0] pin_in
);
    logic toggle_q = 1'b0;
    always @(posedge clk) toggle_q <= ~toggle_q;
    // Strong pad drive wins, then the board, then weak pulls
    always_comb
    begin
        for (int p = 0; p < NPORT; p++)
            for (int b = 0; b < NPIN; b++)
                if (!pad[p].oe_n[b]) pin_in[p*NPIN+b] = pad[p].dout[b];
                else if (ext_en[p*NPIN+b]) pin_in[p*NPIN+b] = ext_val[p*NPIN+b];
                else if (pad[p].weak_up[b]) pin_in[p*NPIN+b] = 1'b1;
                else if (pad[p].weak_dn[b]) pin_in[p*NPIN+b] = 1'b0;
                else pin_in[p*NPIN+b] = toggle_q ^ b[0];
    end
endmodule : gpr_board

// ==== sim/gpr_port_bench.sv ====
// Purpose: Self-checking bench for the GPIO ports over APB
// Assumes: Zero wait-state slave, registered pads and pin sampling
// Notes: Expected answers of every access, reads and writes, are queued by the driver and compared by a monitor
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin fails++; \
    $display("Error %s expected %h seen %h", nm, ex, gt); end end
module gpr_port_bench;
    import gpr_pkg::*;
    logic clk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    gpr_pad_t [NPORT-1:0] pad;
    gpr_sig_t [NPORT-1:0] ic_sig;
    gpr_sig_t [NPORT-1:0][7:0] periph_sig;
    logic [NPORT*NPIN-1:0] pin_in, ic_in, sense_en, shield_en, bus_a_en, bus_b_en, ext_en, ext_val;
    logic [NPORT-1:0] port_irq;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    int fails = 0;
    int total_checks = 0;
    gpr_port i_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pad(pad), .ic_sig(ic_sig), .periph_sig(periph_sig), .ic_in(ic_in),
        .sense_en(sense_en), .shield_en(shield_en), .bus_a_en(bus_a_en), .bus_b_en(bus_b_en),
        .port_irq(port_irq));
    gpr_board i_board (.clk(clk), .pad(pad), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
        if (psel && penable && pready)
        begin
            e = exp_q.pop_front();
            `CHK("apb answer", e, {pslverr, prdata})
        end
    task automatic report_and_stop();
        if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] x);
        int n;
        exp_q.push_back(x);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) fails++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, {1'b0, 32'h0});
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] v);
        apb(1'b0, a, 32'h0, {1'b0, v});
    endtask : rd
    initial
    begin
        #200000;
        fails++;
        report_and_stop();
    end
    initial
    begin
        void'($urandom(32'hCEFA990E));
        {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
        ext_en = 40'hFF_FFFF_FF00;
        ext_val = '0;
        ic_sig = '0;
        for (int p = 0; p < NPORT; p++)
            for (int c = 0; c < 8; c++)
                periph_sig[p][c] = gpr_sig_t'($urandom());
        repeat (6) @(posedge clk);
        for (int p = 0; p < NPORT; p++)
        begin
            `CHK("reset oe_n", 8'hFF, pad[p].oe_n)
            `CHK("reset in_en", 8'h00, pad[p].in_en)
        end
        `CHK("reset irq", 5'h00, port_irq)
        sys_rst <= 1'b0;
        @(posedge clk);
        rd(12'h010, 32'h0);
        rv = $urandom();
        wr(12'h050, rv);
        rd(12'h050, rv);
        wr(12'h050, 32'h0);
        apb(1'b1, 12'h020, 32'hFFFF_FFFF, {1'b1, 32'h0});
        apb(1'b0, 12'h020, 32'h0, {1'b1, 32'h0});
        apb(1'b0, 12'h140, 32'h0, {1'b1, 32'h0});
        wr(12'h048, 32'h00FA_C688);
        rd(12'h048, 32'h00FA_C688);
        wr(12'h04C, 32'h55AA_FFFF);
        rd(12'h04C, 32'h55AA_FFFF);
        repeat (2) @(posedge clk);
        `CHK("lvttl", 8'hAA, pad[1].lvttl)
        `CHK("slow", 8'h55, pad[1].slow)
        `CHK("analog in_en", 1'b0, pad[1].in_en[0])
        `CHK("input oe_n", 1'b1, pad[1].oe_n[1])
        `CHK("strong oe_n", 1'b0, pad[1].oe_n[6])
        wr(12'h048, 32'h00DB_6DB6);
        rv = {24'h0, 8'($urandom())};
        wr(12'h040, rv);
        repeat (3) @(posedge clk);
        rd(12'h044, rv);
        `CHK("ic in", rv[7:0], ic_in[15:8])
        wr(12'h05C, 32'h0000_00FF);
        wr(12'h040, ~rv & 32'h0000_00FF);
        rd(12'h040, ~rv & 32'h0000_00FF);
        repeat (2) @(posedge clk);
        `CHK("held dout", rv[7:0], pad[1].dout)
        rd(12'h044, rv);
        ic_sig[3].dout <= 8'($urandom());
        wr(12'h0D0, 32'h7654_0280);
        repeat (2) @(posedge clk);
        `CHK("route ic", ic_sig[3].dout[2], pad[3].dout[2])
        `CHK("route fixed", periph_sig[3][0].dout[1], pad[3].dout[1])
        `CHK("route analog", 4'hF, {bus_b_en[31], bus_a_en[30], shield_en[29], sense_en[28]})
        wr(12'h100, 32'h0000_00FF);
        rd(12'h100, 32'h0000_000F);
        wr(12'h08C, 32'h0000_00FF);
        wr(12'h098, 32'h0000_0001);
        ext_val[17] <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("masked irq", 1'b0, port_irq[2])
        ext_val[16] <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK("port irq", 1'b1, port_irq[2])
        rd(12'h094, 32'h0000_0003);
        `CHK("cleared irq", 1'b0, port_irq[2])
        rd(12'h094, 32'h0);
        report_and_stop();
    end
endmodule : gpr_port_bench
